// [src/analog_output_sequencer.sv]
// Output sequencer: APB registers, trigger and clock handling, DAC pacing
// Assumes ext_start, ext_stop and ext_clk are asynchronous pins
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "aoseq_map.svh"
module analog_output_sequencer (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_start,
	input wire logic ext_stop,
	input wire logic ext_clk,
	output logic [15:0] dac_data,
	output logic [2:0] dac_chan,
	output logic dac_load,
	output logic running,
	output logic irq
);
	default clocking dflt_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic fall);
		edge_hit = fall ? (prev & ~cur) : (~prev & cur);
	endfunction: edge_hit
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction: hit
	sample_buf_if sbuf ();
	sample_buffer u_buf (
		.mclk(mclk),
		.rst_b(rst_b),
		.bus(sbuf.store)
	);
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [8:0] ctrl_reg, ctrl_next;
	logic [31:0] tgt_reg, tgt_next, produced_reg, produced_next;
	logic [15:0] div_reg, div_next, data_reg, data_next;
	logic [2:0] sync1_reg, sync2_reg, prev_reg;
	logic [1:0] flt_lvl_reg, flt_lvl_next;
	logic [3:0] flt_cnt_reg [2], flt_cnt_next [2];
	aoseq_pkg::seq_state_t state_reg, state_next;
	logic [2:0] chan_reg, chan_next, dchan_reg, dchan_next;
	logic [6:0] conv_reg, conv_next;
	logic [15:0] div_cnt_reg, div_cnt_next, eff_div;
	logic load_reg, load_next, irq_reg, run_reg, tick, count_stop;
	logic [3:0] mask_reg, mask_next, sts_reg, sts_next, sts_set, sts_clr;
	logic [7:0] gap_reg;
	logic wr_fire, rd_fire, sw_start, sw_stop, start_evt, stop_evt, clk_evt;
	aoseq_pkg::stop_src_t stop_src;

	assign wr_fire = psel & penable & pwrite & pready_reg;
	assign rd_fire = psel & penable & ~pready_reg;
	assign sw_start = wr_fire & hit(paddr, `AOS_OFF_CMD) & pwdata[`AOS_CMD_START];
	assign sw_stop = wr_fire & hit(paddr, `AOS_OFF_CMD) & pwdata[`AOS_CMD_STOP];
	assign sts_clr = (wr_fire & hit(paddr, `AOS_OFF_STATUS)) ? pwdata[3:0] : 4'h0;
	assign sbuf.push = wr_fire & hit(paddr, `AOS_OFF_DATA);
	assign sbuf.push_data = pwdata[15:0];
	assign sbuf.clear = wr_fire & hit(paddr, `AOS_OFF_CMD) & pwdata[`AOS_CMD_CLEAR];
	assign sbuf.ring = ctrl_reg[`AOS_F_RING];
	assign stop_src = aoseq_pkg::stop_src_t'(ctrl_reg[`AOS_F_STOP_SRC+1:`AOS_F_STOP_SRC]);
	assign eff_div = (div_reg < 16'(`AOS_CONV_CYC)) ? 16'(`AOS_CONV_CYC) : div_reg;
	assign start_evt = ctrl_reg[`AOS_F_START_SRC]
		? edge_hit(prev_reg[0], flt_lvl_reg[0], ctrl_reg[`AOS_F_START_FALL])
		: sw_start;
	assign stop_evt = edge_hit(prev_reg[1], flt_lvl_reg[1], ctrl_reg[`AOS_F_STOP_FALL]);
	// Clock pin goes straight from the synchroniser to the edge detector
	assign clk_evt = edge_hit(prev_reg[2], sync2_reg[2], ctrl_reg[`AOS_F_CLK_FALL]);

	// Register file and APB answer, one wait state
	always_comb
	begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		tgt_next = tgt_reg;
		div_next = div_reg;
		prdata_next = 32'h0000_0000;
		pslverr_next = 1'b0;
		pready_next = rd_fire;
		if (wr_fire && hit(paddr, `AOS_OFF_CTRL))
			ctrl_next = pwdata[8:0];
		if (wr_fire && hit(paddr, `AOS_OFF_MASK))
			mask_next = pwdata[3:0];
		if (wr_fire && hit(paddr, `AOS_OFF_COUNT))
			tgt_next = pwdata;
		if (wr_fire && hit(paddr, `AOS_OFF_DIV))
			div_next = pwdata[15:0];
		if (rd_fire)
		begin
			case (paddr)
				`AOS_OFF_CTRL: prdata_next = {23'h000000, ctrl_reg};
				`AOS_OFF_CMD: prdata_next = 32'h0000_0000;
				`AOS_OFF_STATUS: prdata_next = {16'h0000, 4'h0, sts_reg, 5'h00,
					sbuf.full, sbuf.empty, run_reg};
				`AOS_OFF_MASK: prdata_next = {28'h0000000, mask_reg};
				`AOS_OFF_COUNT: prdata_next = tgt_reg;
				`AOS_OFF_DIV: prdata_next = {16'h0000, div_reg};
				`AOS_OFF_DATA: prdata_next = {21'h000000, sbuf.level};
				`AOS_OFF_PRODUCED: prdata_next = produced_reg;
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	// Chatter filter: a new level must hold for the full filter time
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			flt_lvl_next[i] = flt_lvl_reg[i];
			flt_cnt_next[i] = 4'h0;
			if (!ctrl_reg[`AOS_F_FILTER])
				flt_lvl_next[i] = sync2_reg[i];
			else if (sync2_reg[i] != flt_lvl_reg[i])
			begin
				if (flt_cnt_reg[i] == 4'(`AOS_FILT_CYC - 1))
					flt_lvl_next[i] = sync2_reg[i];
				else
					flt_cnt_next[i] = flt_cnt_reg[i] + 4'h1;
			end
		end
	end

	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		chan_next = chan_reg;
		conv_next = (conv_reg != 7'h00) ? conv_reg - 7'h01 : conv_reg;
		div_cnt_next = div_cnt_reg;
		produced_next = produced_reg;
		data_next = data_reg;
		load_next = 1'b0;
		sts_set = 4'h0;
		sbuf.pop = 1'b0;
		tick = 1'b0;
		count_stop = 1'b0;
		unique case (state_reg)
			aoseq_pkg::ST_INIT:
				if (conv_reg == 7'h00)
				begin
					data_next = `AOS_ZERO_CODE;
					load_next = 1'b1;
					chan_next = chan_reg + 3'h1;
					conv_next = 7'(`AOS_CONV_CYC - 1);
					if (chan_reg == 3'(`AOS_CHANNELS - 1))
						state_next = aoseq_pkg::ST_IDLE;
				end
			aoseq_pkg::ST_IDLE:
				if (start_evt)
				begin
					state_next = aoseq_pkg::ST_RUN;
					produced_next = 32'h0000_0000;
					div_cnt_next = eff_div - 16'h0001;
					sts_set[`AOS_S_STARTED] = 1'b1;
				end
			aoseq_pkg::ST_RUN:
			begin
				if (!ctrl_reg[`AOS_F_CLK_SRC])
				begin
					tick = (div_cnt_reg == 16'h0000);
					div_cnt_next = tick ? eff_div - 16'h0001 : div_cnt_reg - 16'h0001;
				end
				else
					tick = clk_evt;
				if (tick && conv_reg == 7'h00)
				begin
					if (sbuf.empty)
						sts_set[`AOS_S_UNDERRUN] = ~sbuf.ring;
					else
					begin
						sbuf.pop = 1'b1;
						data_next = sbuf.pop_data;
						load_next = 1'b1;
						chan_next = chan_reg + 3'h1;
						conv_next = 7'(`AOS_CONV_CYC - 1);
						produced_next = produced_reg + 32'h0000_0001;
						if (produced_next == tgt_reg)
						begin
							sts_set[`AOS_S_DONE] = 1'b1;
							count_stop = (stop_src == aoseq_pkg::STOP_COUNT);
						end
					end
				end
				if (sw_stop || count_stop
					|| (stop_src == aoseq_pkg::STOP_EXT && stop_evt))
				begin
					state_next = aoseq_pkg::ST_IDLE;
					sts_set[`AOS_S_STOPPED] = 1'b1;
				end
			end
			default: state_next = aoseq_pkg::ST_INIT;
		endcase
		sts_next = (sts_reg & ~sts_clr) | sts_set;
		dchan_next = chan_next - 3'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			ctrl_reg <= `AOS_CTRL_RST;
			mask_reg <= `AOS_MASK_RST;
			tgt_reg <= `AOS_COUNT_RST;
			div_reg <= `AOS_DIV_RST;
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			prev_reg <= 3'h0;
			flt_lvl_reg <= 2'h0;
			flt_cnt_reg <= '{4'h0, 4'h0};
			state_reg <= aoseq_pkg::ST_INIT;
			chan_reg <= 3'h0;
			dchan_reg <= 3'h7;
			conv_reg <= 7'h00;
			div_cnt_reg <= 16'h0000;
			produced_reg <= 32'h0000_0000;
			data_reg <= `AOS_ZERO_CODE;
			load_reg <= 1'b0;
			sts_reg <= 4'h0;
			irq_reg <= 1'b0;
			run_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			tgt_reg <= tgt_next;
			div_reg <= div_next;
			sync1_reg <= {ext_clk, ext_stop, ext_start};
			sync2_reg <= sync1_reg;
			prev_reg <= {sync2_reg[2], flt_lvl_reg};
			flt_lvl_reg <= flt_lvl_next;
			flt_cnt_reg <= flt_cnt_next;
			state_reg <= state_next;
			chan_reg <= chan_next;
			dchan_reg <= dchan_next;
			conv_reg <= conv_next;
			div_cnt_reg <= div_cnt_next;
			produced_reg <= produced_next;
			data_reg <= data_next;
			load_reg <= load_next;
			sts_reg <= sts_next;
			irq_reg <= |(sts_reg & mask_reg);
			run_reg <= (state_next == aoseq_pkg::ST_RUN);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign dac_data = data_reg;
	assign dac_chan = dchan_reg;
	assign dac_load = load_reg;
	assign running = run_reg;
	assign irq = irq_reg;
	// Cycles since the previous converter load, for checking only
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			gap_reg <= 8'hff;
		else if (load_reg)
			gap_reg <= 8'h01;
		else if (gap_reg != 8'hff)
			gap_reg <= gap_reg + 8'h01;
	end
	property p_sw_start;
		(state_reg == aoseq_pkg::ST_IDLE && !ctrl_reg[`AOS_F_START_SRC] && sw_start)
			|=> (state_reg == aoseq_pkg::ST_RUN) && running;
	endproperty
	a_sw_start: assert property (p_sw_start)
		else $error("software start did not enter run");
	property p_count_stop;
		(state_reg == aoseq_pkg::ST_RUN && sbuf.pop && stop_src == aoseq_pkg::STOP_COUNT
			&& produced_reg + 32'h0000_0001 == tgt_reg)
			|=> (state_reg == aoseq_pkg::ST_IDLE) && sts_reg[`AOS_S_DONE] && !running;
	endproperty
	a_count_stop: assert property (p_count_stop)
		else $error("reaching the sample total did not stop output");
	property p_ext_clk;
		(state_reg == aoseq_pkg::ST_RUN && ctrl_reg[`AOS_F_CLK_SRC] && clk_evt
			&& conv_reg == 7'h00 && !sbuf.empty)
			|=> dac_load ##1 !dac_load;
	endproperty
	a_ext_clk: assert property (p_ext_clk)
		else $error("external clock edge did not load a sample");
	property p_init_zero;
		(state_reg == aoseq_pkg::ST_INIT && conv_reg == 7'h00)
			|=> dac_load && dac_data == `AOS_ZERO_CODE;
	endproperty
	a_init_zero: assert property (p_init_zero)
		else $error("power-up load was not the zero-volt code");
	property p_filter_hold;
		(ctrl_reg[`AOS_F_FILTER] && $past(ctrl_reg[`AOS_F_FILTER])
			&& $changed(flt_lvl_reg[0]))
			|-> $past(flt_cnt_reg[0]) == 4'(`AOS_FILT_CYC - 1);
	endproperty
	a_filter_hold: assert property (p_filter_hold)
		else $error("filtered start level changed before the filter time");
	property p_conv_gap;
		dac_load |-> gap_reg >= 8'(`AOS_CONV_CYC);
	endproperty
	a_conv_gap: assert property (p_conv_gap)
		else $error("converter loads closer than the conversion time");
	property p_irq;
		(|(sts_reg & mask_reg)) |=> irq ##1 (irq == $past(|(sts_reg & mask_reg)));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt does not follow masked status");
	property p_underrun;
		(state_reg == aoseq_pkg::ST_RUN && tick && conv_reg == 7'h00
			&& sbuf.empty && !sbuf.ring)
			|=> sts_reg[`AOS_S_UNDERRUN] && !dac_load;
	endproperty
	a_underrun: assert property (p_underrun)
		else $error("empty fifo at a tick did not flag underrun");
	property p_count_up;
		(state_reg == aoseq_pkg::ST_RUN && sbuf.pop)
			|=> produced_reg == $past(produced_reg) + 32'h0000_0001;
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("produced sample count did not advance");
endmodule: analog_output_sequencer
`default_nettype wire

// [src/aoseq_map.svh]
// Offsets, field positions, reset values and timing counts of the sequencer
// Assumes a 10 MHz mclk and a word-aligned APB byte address
`ifndef AOSEQ_MAP_SVH
`define AOSEQ_MAP_SVH
`define AOS_OFF_CTRL 8'h00
`define AOS_OFF_CMD 8'h04
`define AOS_OFF_STATUS 8'h08
`define AOS_OFF_MASK 8'h0c
`define AOS_OFF_COUNT 8'h10
`define AOS_OFF_DIV 8'h14
`define AOS_OFF_DATA 8'h18
`define AOS_OFF_PRODUCED 8'h1c
`define AOS_F_START_SRC 0
`define AOS_F_STOP_SRC 1
`define AOS_F_CLK_SRC 3
`define AOS_F_START_FALL 4
`define AOS_F_STOP_FALL 5
`define AOS_F_CLK_FALL 6
`define AOS_F_FILTER 7
`define AOS_F_RING 8
`define AOS_CMD_START 0
`define AOS_CMD_STOP 1
`define AOS_CMD_CLEAR 2
`define AOS_S_UNDERRUN 0
`define AOS_S_DONE 1
`define AOS_S_STARTED 2
`define AOS_S_STOPPED 3
`define AOS_CTRL_RST 9'h000
`define AOS_MASK_RST 4'h0
`define AOS_COUNT_RST 32'h0000_0000
`define AOS_DIV_RST 16'h0064
`define AOS_ZERO_CODE 16'h8000
`define AOS_BUF_DEPTH 1024
`define AOS_CHANNELS 8
`define AOS_CLK_PERIOD_NS 100
`define AOS_FILT_NS 1000
`define AOS_CONV_NS 10000
`define AOS_FILT_CYC ((`AOS_FILT_NS + `AOS_CLK_PERIOD_NS - 1) / `AOS_CLK_PERIOD_NS)
`define AOS_CONV_CYC ((`AOS_CONV_NS + `AOS_CLK_PERIOD_NS - 1) / `AOS_CLK_PERIOD_NS)
`endif

// [src/aoseq_pkg.sv]
// Types shared by the sequencer and its sample buffer
// Assumes nothing beyond a SystemVerilog package scope
`default_nettype none
package aoseq_pkg;
	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;
	typedef enum logic [1:0] {
		STOP_COUNT = 2'b00,
		STOP_EXT = 2'b01,
		STOP_SW = 2'b10
	} stop_src_t;
	typedef logic [15:0] sample_t;
	typedef logic [10:0] bptr_t;
endpackage: aoseq_pkg
`default_nettype wire

// [src/sample_buf_if.sv]
// Carrier between the sequencer and its sample buffer
// Assumes both ends run on the same mclk
`timescale 1ns/10ps
`default_nettype none
interface sample_buf_if;
	logic push;
	aoseq_pkg::sample_t push_data;
	logic pop;
	logic clear;
	logic ring;
	aoseq_pkg::sample_t pop_data;
	logic empty;
	logic full;
	aoseq_pkg::bptr_t level;
	modport seq (output push, push_data, pop, clear, ring,
		input pop_data, empty, full, level);
	modport store (input push, push_data, pop, clear, ring,
		output pop_data, empty, full, level);
endinterface: sample_buf_if
`default_nettype wire

// [src/sample_buffer.sv]
// 1K-word sample store, run as FIFO or as a replaying ring
// Assumes push is ignored when full and pop when empty
`timescale 1ns/10ps
`default_nettype none
`include "aoseq_map.svh"
module sample_buffer (
	input wire logic mclk,
	input wire logic rst_b,
	sample_buf_if.store bus
);
	aoseq_pkg::sample_t mem [0:`AOS_BUF_DEPTH-1];
	aoseq_pkg::bptr_t wr_reg;
	aoseq_pkg::bptr_t wr_next;
	aoseq_pkg::bptr_t rd_reg;
	aoseq_pkg::bptr_t rd_next;
	aoseq_pkg::bptr_t rd_inc;

	assign rd_inc = rd_reg + 11'h001;
	// Ring keeps its words and replays from the start
	assign bus.empty = bus.ring ? (wr_reg == 11'h000) : (wr_reg == rd_reg);
	assign bus.level = bus.ring ? wr_reg : (wr_reg - rd_reg);
	assign bus.full = bus.level[10];
	assign bus.pop_data = mem[rd_reg[9:0]];

	always_comb
	begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (bus.clear)
		begin
			wr_next = 11'h000;
			rd_next = 11'h000;
		end
		else
		begin
			if (bus.push && !bus.full)
				wr_next = wr_reg + 11'h001;
			if (bus.pop && !bus.empty)
				rd_next = (bus.ring && rd_inc == wr_reg) ? 11'h000 : rd_inc;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			wr_reg <= 11'h000;
			rd_reg <= 11'h000;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (bus.push && !bus.full && !bus.clear)
			mem[wr_reg[9:0]] <= bus.push_data;
	end

	property p_ring_keep;
		@(posedge mclk) disable iff (!rst_b)
		(bus.ring && bus.pop && !bus.empty && !bus.push && !bus.clear)
			|=> (bus.level == $past(bus.level));
	endproperty
	a_ring_keep: assert property (p_ring_keep)
		else $error("ring pop changed the stored word count");

	property p_fifo_drain;
		@(posedge mclk) disable iff (!rst_b)
		(!bus.ring && bus.pop && !bus.empty && !bus.push && !bus.clear)
			|=> (bus.level == $past(bus.level) - 11'h001);
	endproperty
	a_fifo_drain: assert property (p_fifo_drain)
		else $error("fifo pop did not remove one word");
endmodule: sample_buffer
`default_nettype wire

// [verification/dac_bank.sv]
// Model of the eight-channel converter bank fed by the sequencer
// Assumes dac_data and dac_chan are valid in the cycle dac_load is high
`timescale 1ns/10ps
`default_nettype none
module dac_bank (
	input wire logic mclk,
	input wire logic [15:0] dac_data,
	input wire logic [2:0] dac_chan,
	input wire logic dac_load
);
	logic [15:0] held [8];
	logic [15:0] got_q [$];
	logic [2:0] chan_q [$];
	// One latch per channel, changed only by a load
	always @(posedge mclk)
	begin
		if (dac_load === 1'b1)
		begin
			held[dac_chan] <= dac_data;
			got_q.push_back(dac_data);
			chan_q.push_back(dac_chan);
		end
	end
endmodule: dac_bank
`default_nettype wire

// [verification/test_analog_output_sequencer.sv]
// Self-checking bench for the output sequencer and a converter bank model
// Assumes mclk at 10 MHz and the register map of aoseq_map.svh
`timescale 1ns/10ps
`default_nettype none
`include "aoseq_map.svh"
module test_analog_output_sequencer;
	logic mclk;
	logic rst_b;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_start;
	logic ext_stop;
	logic ext_clk;
	logic [15:0] dac_data;
	logic [2:0] dac_chan;
	logic dac_load;
	logic running;
	logic irq;
	logic [31:0] rdat;
	logic rerr;
	logic [2:0] ch_nx;
	logic [15:0] smp [3];
	logic [7:0] offs [5];
	logic [31:0] rstv [5];
	int mismatches;
	int checks;

	analog_output_sequencer dut_u (.mclk, .rst_b, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_start, .ext_stop, .ext_clk, .dac_data, .dac_chan,
		.dac_load, .running, .irq);
	dac_bank model_u (.mclk, .dac_data, .dac_chan, .dac_load);

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic close_out();
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask: close_out

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask: chk

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask: idle

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("wait", n, 32'h2);
	endtask: apb

	task automatic fill(input int n);
		for (int i = 0; i < n; i++)
		begin
			smp[i] = 16'($urandom());
			apb(1'b1, `AOS_OFF_DATA, {16'h0, smp[i]});
		end
	endtask: fill

	task automatic wait_loads(input int n, input int lim);
		int k;
		k = 0;
		while (model_u.got_q.size() < n && k < lim)
		begin
			@(posedge mclk);
			k++;
		end
		chk("loads", model_u.got_q.size(), n);
	endtask: wait_loads

	// Pops one load and expects the next channel in turn
	task automatic take(input logic [15:0] e);
		chk("dac_data", {16'h0, model_u.got_q.pop_front()}, {16'h0, e});
		chk("dac_chan", {29'h0, model_u.chan_q.pop_front()}, {29'h0, ch_nx});
		ch_nx = ch_nx + 3'h1;
	endtask: take

	function automatic logic [31:0] bit_of(input logic b);
		return {31'h0, b};
	endfunction: bit_of

	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_start = 1'b1;
		ext_stop = 1'b0;
		ext_clk = 1'b1;
		ch_nx = 3'h0;
		offs = '{`AOS_OFF_CTRL, `AOS_OFF_MASK, `AOS_OFF_COUNT,
			`AOS_OFF_DIV, `AOS_OFF_CMD};
		rstv = '{32'h0, 32'h0, 32'h0, 32'h64, 32'h0};
		void'($urandom(32'h1b1d22da));
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		wait_loads(8, 1200);
		for (int i = 0; i < 8; i++)
			take(16'h8000);
		foreach (offs[i])
		begin
			apb(1'b0, offs[i], 32'h0);
			chk("reset value", rdat, rstv[i]);
		end
		apb(1'b0, 8'h20, 32'h0);
		chk("pslverr", bit_of(rerr), 32'h1);
		// FIFO run on the internal clock, ended by the count
		fill(3);
		apb(1'b0, `AOS_OFF_DATA, 32'h0);
		chk("level", rdat, 32'h3);
		apb(1'b1, `AOS_OFF_COUNT, 32'h3);
		apb(1'b1, `AOS_OFF_MASK, 32'h2);
		apb(1'b1, `AOS_OFF_CMD, 32'h1);
		idle(90);
		chk("early", model_u.got_q.size(), 0);
		wait_loads(3, 400);
		foreach (smp[i])
			take(smp[i]);
		idle(3);
		chk("running", bit_of(running), 32'h0);
		chk("irq", bit_of(irq), 32'h1);
		apb(1'b0, `AOS_OFF_PRODUCED, 32'h0);
		chk("produced", rdat, 32'h3);
		apb(1'b1, `AOS_OFF_STATUS, 32'h2);
		idle(2);
		chk("irq", bit_of(irq), 32'h0);
		// Empty FIFO while running, then forced stop
		apb(1'b1, `AOS_OFF_COUNT, 32'h0);
		apb(1'b1, `AOS_OFF_MASK, 32'h1);
		apb(1'b1, `AOS_OFF_CMD, 32'h1);
		idle(250);
		apb(1'b0, `AOS_OFF_STATUS, 32'h0);
		chk("underrun", bit_of(rdat[8]), 32'h1);
		chk("irq", bit_of(irq), 32'h1);
		apb(1'b1, `AOS_OFF_CMD, 32'h2);
		idle(2);
		chk("running", bit_of(running), 32'h0);
		apb(1'b1, `AOS_OFF_STATUS, 32'hf);
		apb(1'b1, `AOS_OFF_MASK, 32'h0);
		// External start, clock and stop with filter and edge choice
		apb(1'b1, `AOS_OFF_CTRL, 32'hdb);
		fill(2);
		ext_start <= 1'b0;
		idle(4);
		ext_start <= 1'b1;
		idle(30);
		chk("running", bit_of(running), 32'h0);
		ext_start <= 1'b0;
		idle(30);
		chk("running", bit_of(running), 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			chk("loads", model_u.got_q.size(), 0);
			ext_clk <= 1'b0;
			wait_loads(1, 8);
			take(smp[i]);
			idle(110);
			ext_clk <= 1'b1;
			idle(110);
		end
		ext_stop <= 1'b1;
		idle(30);
		chk("running", bit_of(running), 32'h0);
		// Ring replays its stored words
		apb(1'b1, `AOS_OFF_CTRL, 32'h100);
		apb(1'b1, `AOS_OFF_CMD, 32'h4);
		fill(2);
		apb(1'b1, `AOS_OFF_COUNT, 32'h5);
		apb(1'b1, `AOS_OFF_DIV, 32'hc8);
		apb(1'b1, `AOS_OFF_CMD, 32'h1);
		idle(150);
		chk("early", model_u.got_q.size(), 0);
		wait_loads(5, 1200);
		for (int i = 0; i < 5; i++)
			take(smp[i % 2]);
		idle(1);
		chk("held", {16'h0, model_u.held[1]}, {16'h0, smp[0]});
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		close_out();
	end
endmodule: test_analog_output_sequencer
`default_nettype wire
